// >>> logic/cfc_pkg.sv
// Constants shared by the CCD front end control port
package cfc_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_VIDEO_OPT = 8'h00;
  localparam logic [7:0] ADDR_GAIN      = 8'h04;
  localparam logic [7:0] ADDR_OFFSET    = 8'h08;
  localparam logic [7:0] ADDR_AUX_DAC   = 8'h0C;
  localparam logic [7:0] ADDR_SETUP     = 8'h10;
  localparam logic [7:0] ADDR_DAC_TWO   = 8'h14;
  localparam logic [7:0] ADDR_STATUS    = 8'h18;
  localparam logic [7:0] ADDR_PIXEL     = 8'h1C;
  // Field positions
  localparam int OPT_AUTO_GAIN   = 0;
  localparam int OPT_AUTO_BRIGHT = 1;
  localparam int OPT_ENABLE      = 2;
  localparam int HI_FIELD        = 16;
  localparam int SEL_POS         = 24;
  // Reset values
  localparam logic [31:0] RST_VIDEO_OPT = 32'h0000_0000;
  localparam logic [31:0] RST_GAIN      = 32'h0000_0000;
  localparam logic [31:0] RST_OFFSET    = 32'h0000_0000;
  localparam logic [31:0] RST_AUX_DAC   = 32'h0000_0000;
  localparam logic [31:0] RST_SETUP     = 32'h0000_0000;
  localparam logic [31:0] RST_DAC_TWO   = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Serial word and front end register addresses
  // ----------------------------------------------------------------
  localparam int SER_AW = 6;
  localparam int SER_DW = 10;
  localparam int SER_W  = SER_AW + SER_DW;
  localparam int N_TGT  = 7;
  localparam logic [SER_AW-1:0] AFE_GAIN   = 6'h01;
  localparam logic [SER_AW-1:0] AFE_COARSE = 6'h02;
  localparam logic [SER_AW-1:0] AFE_FINE   = 6'h03;
  localparam logic [SER_AW-1:0] AFE_OBLVL  = 6'h04;
  localparam logic [SER_AW-1:0] AFE_OBCAL  = 6'h05;
  localparam logic [SER_AW-1:0] AFE_AUX_CONVERTER_ONE   = 6'h06;
  localparam logic [SER_AW-1:0] AFE_AUX_CONVERTER_TWO   = 6'h07;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ     = 125;
  localparam int SER_HALF_NS = 82;
  localparam logic [4:0] SER_HALF_CYC = 5'((SER_HALF_NS * CLK_MHZ + 999) / 1000);
  localparam logic [1:0] PIX_DIV_M1   = 2'h3;
  localparam logic [9:0] LINE_PIX_M1  = 10'h30B;
  localparam logic [9:0] CLAMP_BEG    = 10'h004;
  localparam logic [9:0] CLAMP_END    = 10'h008;
  localparam logic [9:0] ACT_BEG      = 10'h020;
  localparam logic [9:0] OB_BEG_0     = 10'h010;
  localparam logic [9:0] OB_BEG_1     = 10'h012;
  localparam logic [9:0] OB_BEG_2     = 10'h014;
  localparam logic [9:0] OB_BEG_3     = 10'h00C;
  typedef enum logic [3:0] {
    SER_IDLE  = 4'b0001,
    SER_LOW   = 4'b0010,
    SER_HIGH  = 4'b0100,
    SER_LATCH = 4'b1000
  } cfc_ser_t;
endpackage

// >>> logic/cfc_top.sv
// CCD front end control port: sampling strobes, black window, serial programming, pixel capture
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
module cfc_top
  import cfc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        frame_start,
  input  wire logic [9:0]  loop_gain,
  input  wire logic [9:0]  loop_coarse,
  input  wire logic [9:0]  loop_fine,
  output logic             dc_restore_n,
  output logic             reset_pedestal_sample,
  output logic             video_pedestal_sample,
  output logic             optical_black_window_n,
  output logic             ser_clk,
  output logic             ser_data,
  output logic             ser_load_n,
  input  wire logic        converter_data_clock,
  input  wire logic        conv_reset_n,
  input  wire logic [9:0]  conv_pixel,
  output logic      [9:0]  pixel_data,
  output logic             pixel_valid
);
  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0]      video_options_reg;
  logic [31:0]      manual_gain_reg;
  logic [31:0]      manual_offset_reg;
  logic [31:0]      aux_dac_level_reg;
  logic [31:0]      frontend_setup_reg;
  logic [31:0]      dac_two_reg;
  logic [N_TGT-1:0] pend;
  logic             ser_busy;
  logic             wr_hit;
  logic             rd_hit;
  logic [31:0]      rd_val;
  logic             rd_ok;

  assign wr_hit = psel & penable & pready & pwrite;
  assign rd_hit = psel & penable & ~pready;

  wire auto_gain   = video_options_reg[OPT_AUTO_GAIN];
  wire auto_bright = video_options_reg[OPT_AUTO_BRIGHT];
  wire run_en      = video_options_reg[OPT_ENABLE];
  wire [4:0] lines_smpl = frontend_setup_reg[4:0];
  wire [4:0] pix_smpl   = frontend_setup_reg[HI_FIELD +: 5];
  wire [1:0] ccd_sel    = frontend_setup_reg[SEL_POS +: 2];

  always_comb
  begin
    rd_ok  = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      ADDR_VIDEO_OPT: rd_val = video_options_reg;
      ADDR_GAIN:      rd_val = manual_gain_reg;
      ADDR_OFFSET:    rd_val = manual_offset_reg;
      ADDR_AUX_DAC:   rd_val = aux_dac_level_reg;
      ADDR_SETUP:     rd_val = frontend_setup_reg;
      ADDR_DAC_TWO:   rd_val = dac_two_reg;
      ADDR_STATUS:    rd_val = {24'h00_0000, pend, ser_busy};
      ADDR_PIXEL:     rd_val = {22'h00_0000, pixel_data};
      default:        rd_ok  = 1'b0;
    endcase
  end

  // One wait state: answer follows the first access cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= rd_hit;
      pslverr <= rd_hit & ~rd_ok;
      if (rd_hit)
        prdata <= pwrite ? 32'h0000_0000 : rd_val;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      video_options_reg  <= RST_VIDEO_OPT;
      manual_gain_reg    <= RST_GAIN;
      manual_offset_reg  <= RST_OFFSET;
      aux_dac_level_reg  <= RST_AUX_DAC;
      frontend_setup_reg <= RST_SETUP;
      dac_two_reg        <= RST_DAC_TWO;
    end
    else if (wr_hit)
    begin
      case (paddr)
        ADDR_VIDEO_OPT: video_options_reg  <= pwdata;
        ADDR_GAIN:      manual_gain_reg    <= pwdata;
        ADDR_OFFSET:    manual_offset_reg  <= pwdata;
        ADDR_AUX_DAC:   aux_dac_level_reg  <= pwdata;
        ADDR_SETUP:     frontend_setup_reg <= pwdata;
        ADDR_DAC_TWO:   dac_two_reg        <= pwdata;
        default:        ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Line timing
  // ----------------------------------------------------------------
  logic [1:0] phase;
  logic [9:0] pix_cnt;
  logic [4:0] line_cnt;

  function automatic logic [9:0] ob_start(input logic [1:0] sel);
    case (sel)
      2'd0:    ob_start = OB_BEG_0;
      2'd1:    ob_start = OB_BEG_1;
      2'd2:    ob_start = OB_BEG_2;
      default: ob_start = OB_BEG_3;
    endcase
  endfunction

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phase    <= 2'h0;
      pix_cnt  <= 10'h000;
      line_cnt <= 5'h00;
    end
    else if (!run_en || frame_start)
    begin
      phase    <= 2'h0;
      pix_cnt  <= 10'h000;
      line_cnt <= 5'h00;
    end
    else if (phase == PIX_DIV_M1)
    begin
      phase <= 2'h0;
      if (pix_cnt == LINE_PIX_M1)
      begin
        pix_cnt <= 10'h000;
        if (line_cnt != 5'h1F)
          line_cnt <= line_cnt + 5'h01;
      end
      else
        pix_cnt <= pix_cnt + 10'h001;
    end
    else
      phase <= phase + 2'h1;
  end

  wire [9:0] ob_beg = ob_start(ccd_sel);
  wire [9:0] ob_end = ob_beg + {5'h00, pix_smpl};
  wire in_active = run_en && pix_cnt >= ACT_BEG;

  // Clamped bias holds the whole line, so a short strobe suffices
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dc_restore_n           <= 1'b1;
      reset_pedestal_sample  <= 1'b0;
      video_pedestal_sample  <= 1'b0;
      optical_black_window_n <= 1'b1;
    end
    else
    begin
      dc_restore_n <= !(run_en && pix_cnt >= CLAMP_BEG && pix_cnt < CLAMP_END);
      reset_pedestal_sample <= in_active && phase == 2'h0;
      video_pedestal_sample <= in_active && phase == 2'h2;
      optical_black_window_n <= !(run_en && auto_bright && line_cnt < lines_smpl
                                  && pix_cnt >= ob_beg && pix_cnt < ob_end);
    end
  end

  // ----------------------------------------------------------------
  // Serial programming of the front end
  // ----------------------------------------------------------------
  logic [SER_DW-1:0] src     [N_TGT];
  logic [SER_AW-1:0] tgt_adr [N_TGT];
  logic [SER_DW-1:0] last    [N_TGT];
  logic [N_TGT-1:0]  tgt_en;
  logic [N_TGT-1:0]  changed;
  logic [N_TGT-1:0]  clr;
  logic [N_TGT-1:0]  sel_vec;
  logic [1:0]        mode_d;

  always_comb
  begin
    src[0] = auto_gain ? loop_gain : manual_gain_reg[9:0];
    src[1] = auto_bright ? loop_coarse : manual_offset_reg[9:0];
    src[2] = auto_bright ? loop_fine : manual_offset_reg[HI_FIELD +: SER_DW];
    src[3] = aux_dac_level_reg[HI_FIELD +: SER_DW];
    src[4] = {lines_smpl, pix_smpl};
    src[5] = aux_dac_level_reg[9:0];
    src[6] = dac_two_reg[9:0];
    tgt_adr[0] = AFE_GAIN;
    tgt_adr[1] = AFE_COARSE;
    tgt_adr[2] = AFE_FINE;
    tgt_adr[3] = AFE_OBLVL;
    tgt_adr[4] = AFE_OBCAL;
    tgt_adr[5] = AFE_AUX_CONVERTER_ONE;
    tgt_adr[6] = AFE_AUX_CONVERTER_TWO;
    // Black clamp settings only matter while the clamp loop runs
    tgt_en = {2'b11, auto_bright, auto_bright, 3'b111};
  end

  function automatic logic [N_TGT-1:0] first_one(input logic [N_TGT-1:0] v);
    first_one = v & (~v + 7'h01);
  endfunction

  function automatic logic [2:0] idx_of(input logic [N_TGT-1:0] v);
    idx_of = 3'h0;
    for (int k = N_TGT - 1; k >= 0; k--)
      if (v[k])
        idx_of = 3'(k);
  endfunction

  genvar g;
  generate
    for (g = 0; g < N_TGT; g++)
    begin : g_track
      assign changed[g] = src[g] != last[g];
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
          last[g] <= '0;
        else
          last[g] <= src[g];
      end
    end
  endgenerate

  // Both mode bits tracked: swapping gain and brightness modes must re-mark too
  wire [1:0] mode_now = {auto_gain, auto_bright};
  wire [N_TGT-1:0] req = pend & tgt_en;

  cfc_ser_t          st;
  logic [4:0]        div;
  logic [3:0]        bit_cnt;
  logic [SER_W-1:0]  shreg;

  assign ser_busy = st != SER_IDLE;
  assign sel_vec  = first_one(req);
  assign clr      = (st == SER_IDLE) ? sel_vec : '0;

  // A change in the same cycle as a clear keeps the register pending
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pend   <= {N_TGT{1'b1}};
      mode_d <= 2'b00;
    end
    else
    begin
      mode_d <= mode_now;
      pend   <= (pend & ~clr) | changed | {N_TGT{mode_now != mode_d}};
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st         <= SER_IDLE;
      div        <= 5'h00;
      bit_cnt    <= 4'h0;
      shreg      <= '0;
      ser_clk    <= 1'b0;
      ser_data   <= 1'b0;
      ser_load_n <= 1'b1;
    end
    else
    begin
      case (st)
        SER_IDLE:
        begin
          ser_load_n <= 1'b1;
          ser_clk    <= 1'b0;
          if (req != '0)
          begin
            // One word per front end register, address first
            shreg    <= {tgt_adr[idx_of(sel_vec)], src[idx_of(sel_vec)]};
            bit_cnt  <= 4'(SER_W - 1);
            div      <= SER_HALF_CYC;
            st       <= SER_LOW;
            ser_data <= 1'b0;
          end
        end
        SER_LOW:
        begin
          ser_clk  <= 1'b0;
          ser_data <= shreg[SER_W-1];
          if (div == 5'h01)
          begin
            div <= SER_HALF_CYC;
            st  <= SER_HIGH;
          end
          else
            div <= div - 5'h01;
        end
        SER_HIGH:
        begin
          ser_clk <= 1'b1;
          if (div == 5'h01)
          begin
            div   <= SER_HALF_CYC;
            shreg <= {shreg[SER_W-2:0], 1'b0};
            if (bit_cnt == 4'h0)
              st <= SER_LATCH;
            else
            begin
              bit_cnt <= bit_cnt - 4'h1;
              st      <= SER_LOW;
            end
          end
          else
            div <= div - 5'h01;
        end
        SER_LATCH:
        begin
          ser_clk    <= 1'b0;
          ser_load_n <= 1'b0;
          if (div == 5'h01)
            st <= SER_IDLE;
          else
            div <= div - 5'h01;
        end
        default:
          st <= SER_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pixel capture on the converter clock
  // ----------------------------------------------------------------
  // Two slots: each word stays still for two converter periods,
  // longer than the three-flop crossing into clk
  logic [9:0] slot [2];
  logic       wr_slot;
  logic       tog_a;
  logic       tog_s1;
  logic       tog_s2;
  logic       tog_s3;

  always_ff @(posedge converter_data_clock or negedge conv_reset_n)
  begin
    if (!conv_reset_n)
    begin
      slot[0] <= 10'h000;
      slot[1] <= 10'h000;
      wr_slot <= 1'b0;
      tog_a   <= 1'b0;
    end
    else
    begin
      slot[wr_slot] <= conv_pixel;
      wr_slot       <= ~wr_slot;
      tog_a         <= ~tog_a;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tog_s1      <= 1'b0;
      tog_s2      <= 1'b0;
      tog_s3      <= 1'b0;
      pixel_data  <= 10'h000;
      pixel_valid <= 1'b0;
    end
    else
    begin
      tog_s1      <= tog_a;
      tog_s2      <= tog_s1;
      tog_s3      <= tog_s2;
      pixel_valid <= tog_s2 ^ tog_s3;
      if (tog_s2 ^ tog_s3)
        pixel_data <= slot[~tog_s2];
    end
  end
endmodule

// >>> testbench/cfc_assertions.sv
// Concurrent checks on the ports of the CCD front end control port
`timescale 1ns/1ps
module cfc_assertions
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dc_restore_n,
  input wire logic reset_pedestal_sample,
  input wire logic video_pedestal_sample,
  input wire logic optical_black_window_n,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_load_n,
  input wire logic frame_start
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----
  // Helper counters
  // ----
  logic [4:0] bits;
  logic [5:0] low;
  logic       clk_q;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bits <= 5'h00;
      low <= 6'h00;
      clk_q <= 1'b0;
    end
    else
    begin
      clk_q <= ser_clk;
      low <= dc_restore_n ? 6'h00 : low + 6'h01;
      bits <= !ser_load_n ? 5'h00 : bits + 5'(ser_clk & !clk_q);
    end
  end
  sequence s_pair;
    !reset_pedestal_sample ##1 video_pedestal_sample ##1 !video_pedestal_sample;
  endsequence
  sequence s_high;
    ser_clk[*8] ##1 ser_clk[*3] ##1 !ser_clk;
  endsequence
  sequence s_load;
    (!ser_load_n && !ser_clk)[*8] ##1 (!ser_load_n && !ser_clk)[*3] ##1 ser_load_n;
  endsequence
  property p_apb_wait;
    psel && penable && !pready |=> pready;
  endproperty
  property p_err;
    pslverr |-> pready ##1 !pready;
  endproperty
  property p_quiet;
    !dc_restore_n |-> !reset_pedestal_sample && !video_pedestal_sample && optical_black_window_n;
  endproperty
  property p_pair;
    // A restart in the pixel's first two cycles legally drops its video pulse
    reset_pedestal_sample && !frame_start && !$past(frame_start) |=> s_pair;
  endproperty
  property p_restore_width;
    !dc_restore_n |-> low < 6'h10;
  endproperty
  property p_restore_end;
    $rose(dc_restore_n) |-> low == 6'h10 || $past(frame_start, 2);
  endproperty
  property p_clk_high;
    $rose(ser_clk) |-> s_high;
  endproperty
  property p_data_hold;
    ser_clk && $past(ser_clk) |-> $stable(ser_data);
  endproperty
  property p_word_bits;
    $fell(ser_load_n) |-> bits == 5'h10;
  endproperty
  property p_load_len;
    $fell(ser_load_n) |-> s_load;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("pready late");
  a_err: assert property (p_err) else $error("pslverr without pready");
  a_quiet: assert property (p_quiet) else $error("pulse during restore");
  a_pair: assert property (p_pair) else $error("sample pair wrong");
  a_restore_width: assert property (p_restore_width) else $error("restore too long");
  a_restore_end: assert property (p_restore_end) else $error("restore width wrong");
  a_clk_high: assert property (p_clk_high) else $error("serial clock high width");
  a_data_hold: assert property (p_data_hold) else $error("serial data moved");
  a_word_bits: assert property (p_word_bits) else $error("word not 16 bits");
  a_load_len: assert property (p_load_len) else $error("load strobe width");
endmodule

bind cfc_top cfc_assertions u_chk (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .dc_restore_n(dc_restore_n),
  .reset_pedestal_sample(reset_pedestal_sample), .video_pedestal_sample(video_pedestal_sample),
  .optical_black_window_n(optical_black_window_n), .ser_clk(ser_clk), .ser_data(ser_data),
  .ser_load_n(ser_load_n), .frame_start(frame_start));

// >>> testbench/cfc_afe_model.sv
// Behavioural model of the analog front end converter
`timescale 1ns/1ps
module cfc_afe_model
  import cfc_pkg::*;
(
  input  wire logic       run,
  input  wire logic       optical_black_window_n,
  input  wire logic       ser_clk,
  input  wire logic       ser_data,
  input  wire logic       ser_load_n,
  output logic            converter_data_clock,
  output logic [9:0]      conv_pixel
);
  logic [15:0] shift;
  logic [9:0]  regs [0:63];
  int          words = 0;
  int          blk_sum = 0;
  int          blk_n = 0;
  int          fine_trim = 0;
  int          coarse_trim = 0;
  int          clamps = 0;
  localparam int FINE_LIM = 31;
  initial
  begin
    converter_data_clock = 1'b0;
    conv_pixel = 10'h000;
    // Odd start keeps the phase unrelated to the system clock
    #3.1;
    forever #7.5 converter_data_clock = run ? ~converter_data_clock : 1'b0;
  end
  always @(posedge ser_clk)
    shift <= {shift[14:0], ser_data};
  always @(negedge ser_load_n)
  begin
    regs[shift[15:10]] <= shift[9:0];
    words++;
  end
  always @(posedge converter_data_clock)
    conv_pixel <= conv_pixel + 10'h001;
  // Black clamp loop: average each window, trim fine first, coarse only at the fine limit
  always @(posedge converter_data_clock)
    if (optical_black_window_n === 1'b0)
    begin
      blk_sum += conv_pixel;
      blk_n++;
    end
    else if (blk_n > 0)
    begin
      clamps++;
      if (blk_sum / blk_n > int'(regs[AFE_OBLVL]))
      begin
        if (fine_trim > -FINE_LIM)
          fine_trim--;
        else
          coarse_trim--;
      end
      else if (blk_sum / blk_n < int'(regs[AFE_OBLVL]))
      begin
        if (fine_trim < FINE_LIM)
          fine_trim++;
        else
          coarse_trim++;
      end
      blk_sum = 0;
      blk_n = 0;
    end
endmodule

// >>> testbench/cfc_top_test.sv
// Self-checking bench for the CCD front end control port
`timescale 1ns/1ps
module cfc_top_test import cfc_pkg::*;;
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, frame_start = 0, run = 0, cnt_on = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q, rnd = 32'h0000_6814;
  logic [31:0] v [4];
  logic [9:0]  lg, lc, lf, conv_pixel, pixel_data, last;
  logic pready, pslverr, e, dc_restore_n, rps, vps, obw_n, ser_clk, ser_data, ser_load_n, cdc, pixel_valid;
  int num_errors = 0, checked = 0, n_rps, n_vps, n_rst, n_blk, n_pix = 0, w0;
  always #4 clk = ~clk;
  cfc_top u_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_start(frame_start), .loop_gain(lg), .loop_coarse(lc), .loop_fine(lf),
    .dc_restore_n(dc_restore_n), .reset_pedestal_sample(rps), .video_pedestal_sample(vps),
    .optical_black_window_n(obw_n), .ser_clk(ser_clk), .ser_data(ser_data), .ser_load_n(ser_load_n),
    .converter_data_clock(cdc), .conv_reset_n(reset_n), .conv_pixel(conv_pixel),
    .pixel_data(pixel_data), .pixel_valid(pixel_valid));
  cfc_afe_model u_afe (.run(run), .optical_black_window_n(obw_n), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_load_n(ser_load_n),
    .converter_data_clock(cdc), .conv_pixel(conv_pixel));
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic results;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    repeat (20)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    q = prdata;
    e = pslverr;
    // Release at the answering edge, or the slave sees a second access
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      chk("pready", 1, pready);
      results();
    end
  endtask
  // Disabled targets keep their pending flag, so only enabled ones are masked in
  task automatic idle(input logic [7:0] m);
    int n;
    repeat (4) @(posedge clk);
    for (n = 0; n < 1000; n++)
    begin
      apb(1'b0, ADDR_STATUS, 0);
      if ((q[7:0] & m) === 8'h00)
        break;
    end
    chk("serial idle", 0, q[7:0] & m);
    if (n == 1000)
      results();
  endtask
  task automatic lines(input int n);
    @(posedge clk);
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    // First output after the restart edge still shows the old line
    @(posedge clk);
    cnt_on <= 1'b1;
    n_rps = 0;
    n_vps = 0;
    n_rst = 0;
    n_blk = 0;
    repeat (n * 3120) @(posedge clk);
    cnt_on <= 1'b0;
    @(posedge clk);
  endtask
  always @(posedge clk)
    if (cnt_on)
    begin
      n_rps += rps;
      n_vps += vps;
      n_rst += !dc_restore_n;
      n_blk += !obw_n;
    end
  always @(posedge clk)
    if (reset_n && pixel_valid === 1'b1)
    begin
      if (n_pix > 0)
        chk("pixel", 10'(last + 10'h001), pixel_data);
      last = pixel_data;
      n_pix++;
    end
  // ----
  // Main sequence
  // ----
  initial
  begin
    lg = rnd[9:0];
    lc = rnd[19:10];
    lf = rnd[29:20];
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      v[i] = rnd;
    end
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 6; a++)
    begin
      apb(1'b0, 8'(a * 4), 0);
      chk("reset value", 0, q);
    end
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped slverr", 1, e);
    idle(8'hCF);
    chk("words after reset", 5, u_afe.words);
    $display("test reset done");
    w0 = u_afe.words;
    apb(1'b1, ADDR_GAIN, v[0]);
    apb(1'b1, ADDR_OFFSET, v[1]);
    apb(1'b1, ADDR_AUX_DAC, v[2]);
    apb(1'b1, ADDR_DAC_TWO, v[3]);
    idle(8'hCF);
    chk("manual words", w0 + 5, u_afe.words);
    chk("manual gain", v[0][9:0], u_afe.regs[AFE_GAIN]);
    chk("manual coarse", v[1][9:0], u_afe.regs[AFE_COARSE]);
    chk("manual fine", v[1][25:16], u_afe.regs[AFE_FINE]);
    chk("dac one", v[2][9:0], u_afe.regs[AFE_AUX_CONVERTER_ONE]);
    chk("dac two", v[3][9:0], u_afe.regs[AFE_AUX_CONVERTER_TWO]);
    $display("test manual done");
    apb(1'b1, ADDR_SETUP, 32'h0005_0003 | (v[0] & 32'h0300_0000));
    apb(1'b1, ADDR_VIDEO_OPT, 32'h0000_0007);
    idle(8'hFF);
    chk("auto gain", lg, u_afe.regs[AFE_GAIN]);
    chk("auto coarse", lc, u_afe.regs[AFE_COARSE]);
    chk("auto fine", lf, u_afe.regs[AFE_FINE]);
    chk("black level", v[2][25:16], u_afe.regs[AFE_OBLVL]);
    chk("black cal", 10'h065, u_afe.regs[AFE_OBCAL]);
    $display("test auto done");
    run <= 1'b1;
    w0 = u_afe.clamps;
    lines(4);
    chk("clamp windows", w0 + 3, u_afe.clamps);
    chk("reset samples", 2992, n_rps);
    chk("video samples", 2992, n_vps);
    chk("restore low", 64, n_rst);
    chk("black window", 60, n_blk);
    chk("pixels seen", 1, n_pix > 0);
    apb(1'b1, ADDR_VIDEO_OPT, 32'h0000_0005);
    lines(1);
    chk("manual black window", 0, n_blk);
    chk("manual clamp windows", w0 + 3, u_afe.clamps);
    run <= 1'b0;
    $display("test lines done");
    results();
  end
endmodule
